// file: logic/fskcfg_regs.sv
// fskcfg_regs: three byte configuration registers for the fsk baseband,
// reached over axi4-lite, with decoded and registered config outputs.
// assumes synchronous inputs, one clock, asynchronous active-high reset.

`timescale 1ns/1ps
`default_nettype none

// Function
// R01 - 4-bit code selects FSK rate, others prohibited
// R02 - index bit selects modulation index 0.5/1.0
// R03 - rate/index and shaping registers reset zero
// R04 - frame-coding register resets to 8C hex
// R05 - software writes zeros to rate upper bits
// R06 - software writes zeros to shaping upper bits
// R07 - rx FEC enable bit turns decoding on
// R08 - mode bit selects NRNSC or RSC encoder
// R09 - CRC bit selects 32 or 16 bit
// R10 - auto-ACK reply uses received frame CRC length
// R11 - whitening bit enables transmit data whitening
// R12 - two bits copied to header bits 1,2
// R13 - NRNSC encoder requires interleaving enabled
// R14 - MS clear bit forces received MS zero
// R15 - rx shaping bit selects GFSK or FSK
// R16 - tx shaping bit selects GFSK or FSK
// R17 - CCA override uses its own rate/index
// R18 - reserved bits read back as zero
module fskcfg_regs #(
	parameter int ADDR_W = 16
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_reset,
	input  wire logic [ADDR_W-1:0]     i_s_axi_awaddr,
	input  wire logic                  i_s_axi_awvalid,
	output logic                       o_s_axi_awready,
	input  wire logic [31:0]           i_s_axi_wdata,
	input  wire logic [3:0]            i_s_axi_wstrb,
	input  wire logic                  i_s_axi_wvalid,
	output logic                       o_s_axi_wready,
	output logic [1:0]                 o_s_axi_bresp,
	output logic                       o_s_axi_bvalid,
	input  wire logic                  i_s_axi_bready,
	input  wire logic [ADDR_W-1:0]     i_s_axi_araddr,
	input  wire logic                  i_s_axi_arvalid,
	output logic                       o_s_axi_arready,
	output logic [31:0]                o_s_axi_rdata,
	output logic [1:0]                 o_s_axi_rresp,
	output logic                       o_s_axi_rvalid,
	input  wire logic                  i_s_axi_rready,
	input  wire logic                  i_cca_rate_override,
	input  wire logic [3:0]            i_cca_rate_code,
	input  wire logic                  i_cca_mod_index_sel,
	input  wire logic                  i_ack_reply_active,
	input  wire logic                  i_ack_rx_crc_len_sel,
	input  wire logic                  i_rx_ms_bit,
	output logic [3:0]                 o_rate_code,
	output logic                       o_mod_index_sel,
	output logic [11:0]                o_rate_100bps,
	output logic                       o_rate_prohibited,
	output logic [3:0]                 o_cca_rate_code,
	output logic                       o_cca_mod_index_sel,
	output logic [11:0]                o_cca_rate_100bps,
	output logic                       o_cca_rate_prohibited,
	output logic                       o_rx_fec_en,
	output logic                       o_encoder_type_sel,
	output logic                       o_crc_len_sel,
	output logic                       o_whitening_en,
	output logic                       o_hdr_bit1_tx,
	output logic                       o_hdr_bit2_tx,
	output logic                       o_interleave_en,
	output logic                       o_interleave_conflict,
	output logic                       o_rx_ms_clear,
	output logic                       o_rx_ms_bit,
	output logic                       o_rx_shaping_sel,
	output logic                       o_tx_shaping_sel
);

	// ==========================================================
	// elaboration checks
	// ==========================================================
	if (ADDR_W < fskcfg_pkg::REG_ADDR_BITS) begin : g_addr_check
		$error("ADDR_W too narrow for the register map");
	end

	// ==========================================================
	// decoding helpers
	// ==========================================================
	function automatic fskcfg_pkg::fskcfg_sel_t addr_to_sel(input logic [ADDR_W-1:0] addr);
		fskcfg_pkg::fskcfg_sel_t sel;
		sel = fskcfg_pkg::FSKCFG_SEL_NONE;
		if ((addr >> fskcfg_pkg::REG_ADDR_BITS) == '0) begin
			if (addr[fskcfg_pkg::REG_ADDR_BITS-1:0] == fskcfg_pkg::RATE_INDEX_ADDR)
				sel = fskcfg_pkg::FSKCFG_SEL_RATE;
			else if (addr[fskcfg_pkg::REG_ADDR_BITS-1:0] == fskcfg_pkg::FRAME_CODING_ADDR)
				sel = fskcfg_pkg::FSKCFG_SEL_CODING;
			else if (addr[fskcfg_pkg::REG_ADDR_BITS-1:0] == fskcfg_pkg::SHAPING_ADDR)
				sel = fskcfg_pkg::FSKCFG_SEL_SHAPING;
		end
		return sel;
	endfunction

	function automatic logic [11:0] rate_lookup(input logic [3:0] code);
		return fskcfg_pkg::RATE_100BPS[code];
	endfunction

	function automatic logic rate_bad(input logic [3:0] code);
		return !fskcfg_pkg::RATE_ALLOWED[code];
	endfunction

	// ==========================================================
	// write channel
	// ==========================================================
	logic                    aw_full_reg;
	logic                    aw_full_next;
	logic [ADDR_W-1:0]       awaddr_reg;
	logic [ADDR_W-1:0]       awaddr_next;
	logic                    w_full_reg;
	logic                    w_full_next;
	logic [7:0]              wbyte_reg;
	logic [7:0]              wbyte_next;
	logic                    wlane_reg;
	logic                    wlane_next;
	logic                    bvalid_reg;
	logic                    bvalid_next;
	logic [1:0]              bresp_reg;
	logic [1:0]              bresp_next;
	logic                    commit;
	fskcfg_pkg::fskcfg_sel_t wsel;

	assign o_s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign o_s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign o_s_axi_bvalid  = bvalid_reg;
	assign o_s_axi_bresp   = bresp_reg;
	assign commit          = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wsel            = addr_to_sel(awaddr_reg);

	always_comb begin
		aw_full_next = aw_full_reg;
		awaddr_next  = awaddr_reg;
		w_full_next  = w_full_reg;
		wbyte_next   = wbyte_reg;
		wlane_next   = wlane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			aw_full_next = 1'b1;
			awaddr_next  = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			w_full_next = 1'b1;
			wbyte_next  = i_s_axi_wdata[7:0];
			wlane_next  = i_s_axi_wstrb[0];
		end
		if (commit) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (wsel == fskcfg_pkg::FSKCFG_SEL_NONE) ?
				fskcfg_pkg::RESP_SLVERR : fskcfg_pkg::RESP_OKAY;
		end else if (bvalid_reg && i_s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			aw_full_reg <= 1'b0;
			awaddr_reg  <= '0;
			w_full_reg  <= 1'b0;
			wbyte_reg   <= 8'h00;
			wlane_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= fskcfg_pkg::RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			awaddr_reg  <= awaddr_next;
			w_full_reg  <= w_full_next;
			wbyte_reg   <= wbyte_next;
			wlane_reg   <= wlane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// ==========================================================
	// configuration registers
	// ==========================================================
	logic [7:0] rate_index_reg;
	logic [7:0] rate_index_next;
	logic [7:0] frame_coding_reg;
	logic [7:0] frame_coding_next;
	logic [7:0] shaping_reg;
	logic [7:0] shaping_next;

	always_comb begin
		rate_index_next   = rate_index_reg;
		frame_coding_next = frame_coding_reg;
		shaping_next      = shaping_reg;
		if (commit && wlane_reg) begin
			unique case (wsel)
				fskcfg_pkg::FSKCFG_SEL_RATE:
					rate_index_next = wbyte_reg & fskcfg_pkg::RATE_INDEX_MASK;  // see R18
				fskcfg_pkg::FSKCFG_SEL_CODING:
					frame_coding_next = wbyte_reg & fskcfg_pkg::FRAME_CODING_MASK;
				fskcfg_pkg::FSKCFG_SEL_SHAPING:
					shaping_next = wbyte_reg & fskcfg_pkg::SHAPING_MASK;  // see R18
				fskcfg_pkg::FSKCFG_SEL_NONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rate_index_reg   <= fskcfg_pkg::RATE_INDEX_RESET;  // see R03
			frame_coding_reg <= fskcfg_pkg::FRAME_CODING_RESET;  // see R04
			shaping_reg      <= fskcfg_pkg::SHAPING_RESET;  // see R03
		end else begin
			rate_index_reg   <= rate_index_next;
			frame_coding_reg <= frame_coding_next;
			shaping_reg      <= shaping_next;
		end
	end

	// ==========================================================
	// read channel
	// ==========================================================
	logic                    rvalid_reg;
	logic                    rvalid_next;
	logic [31:0]             rdata_reg;
	logic [31:0]             rdata_next;
	logic [1:0]              rresp_reg;
	logic [1:0]              rresp_next;
	fskcfg_pkg::fskcfg_sel_t rsel;

	assign o_s_axi_arready = !rvalid_reg;
	assign o_s_axi_rvalid  = rvalid_reg;
	assign o_s_axi_rdata   = rdata_reg;
	assign o_s_axi_rresp   = rresp_reg;
	assign rsel            = addr_to_sel(i_s_axi_araddr);

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (i_s_axi_arvalid && o_s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = fskcfg_pkg::RESP_OKAY;
			unique case (rsel)
				fskcfg_pkg::FSKCFG_SEL_RATE:    rdata_next = {24'h000000, rate_index_reg};
				fskcfg_pkg::FSKCFG_SEL_CODING:  rdata_next = {24'h000000, frame_coding_reg};
				fskcfg_pkg::FSKCFG_SEL_SHAPING: rdata_next = {24'h000000, shaping_reg};
				fskcfg_pkg::FSKCFG_SEL_NONE: begin
					rdata_next = 32'h00000000;
					rresp_next = fskcfg_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && i_s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= fskcfg_pkg::RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// ==========================================================
	// configuration outputs
	// ==========================================================
	// the upper bits of rate/index and shaping are masked on write, so
	// software that breaks the write-zero convention still sees zeros
	logic [3:0]  rate_code;
	logic [3:0]  cca_code;
	logic        cca_index;
	logic [3:0]  rate_code_reg;
	logic        mod_index_reg;
	logic [11:0] rate_100bps_reg;
	logic        rate_bad_reg;
	logic [3:0]  cca_code_reg;
	logic        cca_index_reg;
	logic [11:0] cca_100bps_reg;
	logic        cca_bad_reg;
	logic [7:0]  coding_out_reg;
	logic        crc_len_reg;
	logic        conflict_reg;
	logic        rx_ms_reg;
	logic [1:0]  shaping_out_reg;
	logic [3:0]  rate_code_next;
	logic        mod_index_next;
	logic [11:0] rate_100bps_next;
	logic        rate_bad_next;
	logic [3:0]  cca_code_next;
	logic        cca_index_next;
	logic [11:0] cca_100bps_next;
	logic        cca_bad_next;
	logic [7:0]  coding_out_next;
	logic        crc_len_next;
	logic        conflict_next;
	logic        rx_ms_next;
	logic [1:0]  shaping_out_next;

	assign rate_code = rate_index_reg[fskcfg_pkg::RATE_CODE_MSB:fskcfg_pkg::RATE_CODE_LSB];
	assign cca_code  = i_cca_rate_override ? i_cca_rate_code : rate_code;  // see R17
	assign cca_index = i_cca_rate_override ? i_cca_mod_index_sel :
		rate_index_reg[fskcfg_pkg::MOD_INDEX_BIT];  // see R17

	always_comb begin
		rate_code_next   = rate_code;  // see R01
		mod_index_next   = rate_index_reg[fskcfg_pkg::MOD_INDEX_BIT];  // see R02
		rate_100bps_next = rate_lookup(rate_code);  // see R01
		rate_bad_next    = rate_bad(rate_code);  // see R01
		cca_code_next    = cca_code;
		cca_index_next   = cca_index;
		cca_100bps_next  = rate_lookup(cca_code);  // see R17
		cca_bad_next     = rate_bad(cca_code);
		coding_out_next  = frame_coding_reg;  // see R07, R08, R11, R12
		crc_len_next     = i_ack_reply_active ? i_ack_rx_crc_len_sel :
			frame_coding_reg[fskcfg_pkg::CRC_LEN_BIT];  // see R09, R10
		conflict_next    = !frame_coding_reg[fskcfg_pkg::ENCODER_TYPE_BIT] &&
			!frame_coding_reg[fskcfg_pkg::INTERLEAVE_BIT];  // see R13
		rx_ms_next       = i_rx_ms_bit &&
			!frame_coding_reg[fskcfg_pkg::RX_MS_CLEAR_BIT];  // see R14
		shaping_out_next = shaping_reg[1:0];  // see R15, R16
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rate_code_reg   <= 4'h0;
			mod_index_reg   <= 1'b0;
			rate_100bps_reg <= 12'h000;
			rate_bad_reg    <= 1'b0;
			cca_code_reg    <= 4'h0;
			cca_index_reg   <= 1'b0;
			cca_100bps_reg  <= 12'h000;
			cca_bad_reg     <= 1'b0;
			coding_out_reg  <= fskcfg_pkg::FRAME_CODING_RESET;
			crc_len_reg     <= 1'b0;
			conflict_reg    <= 1'b0;
			rx_ms_reg       <= 1'b0;
			shaping_out_reg <= 2'h0;
		end else begin
			rate_code_reg   <= rate_code_next;
			mod_index_reg   <= mod_index_next;
			rate_100bps_reg <= rate_100bps_next;
			rate_bad_reg    <= rate_bad_next;
			cca_code_reg    <= cca_code_next;
			cca_index_reg   <= cca_index_next;
			cca_100bps_reg  <= cca_100bps_next;
			cca_bad_reg     <= cca_bad_next;
			coding_out_reg  <= coding_out_next;
			crc_len_reg     <= crc_len_next;
			conflict_reg    <= conflict_next;
			rx_ms_reg       <= rx_ms_next;
			shaping_out_reg <= shaping_out_next;
		end
	end

	assign o_rate_code           = rate_code_reg;
	assign o_mod_index_sel       = mod_index_reg;
	assign o_rate_100bps         = rate_100bps_reg;
	assign o_rate_prohibited     = rate_bad_reg;
	assign o_cca_rate_code       = cca_code_reg;
	assign o_cca_mod_index_sel   = cca_index_reg;
	assign o_cca_rate_100bps     = cca_100bps_reg;
	assign o_cca_rate_prohibited = cca_bad_reg;
	assign o_rx_fec_en           = coding_out_reg[fskcfg_pkg::RX_FEC_EN_BIT];
	assign o_encoder_type_sel    = coding_out_reg[fskcfg_pkg::ENCODER_TYPE_BIT];
	assign o_crc_len_sel         = crc_len_reg;
	assign o_whitening_en        = coding_out_reg[fskcfg_pkg::WHITENING_BIT];
	assign o_hdr_bit1_tx         = coding_out_reg[fskcfg_pkg::HDR_BIT1_BIT];
	assign o_hdr_bit2_tx         = coding_out_reg[fskcfg_pkg::HDR_BIT2_BIT];
	assign o_interleave_en       = coding_out_reg[fskcfg_pkg::INTERLEAVE_BIT];
	assign o_interleave_conflict = conflict_reg;
	assign o_rx_ms_clear         = coding_out_reg[fskcfg_pkg::RX_MS_CLEAR_BIT];
	assign o_rx_ms_bit           = rx_ms_reg;
	assign o_tx_shaping_sel      = shaping_out_reg[fskcfg_pkg::TX_SHAPING_BIT];
	assign o_rx_shaping_sel      = shaping_out_reg[fskcfg_pkg::RX_SHAPING_BIT];

endmodule

`default_nettype wire

// file: logic/fskcfg_pkg.sv
// fskcfg_pkg: register map, field positions, reset values and rate table
// for the fsk baseband configuration register bank.
// assumes a 32-bit axi4-lite bus with one register per aligned word.

package fskcfg_pkg;

	// ==========================================================
	// register indices and byte addresses
	// ==========================================================
	localparam logic [11:0] RATE_INDEX_IDX   = 12'h160;
	localparam logic [11:0] FRAME_CODING_IDX = 12'h161;
	localparam logic [11:0] SHAPING_IDX      = 12'h162;
	localparam int          WORD_SHIFT       = 2;
	localparam logic [13:0] RATE_INDEX_ADDR   = {RATE_INDEX_IDX,   2'b00};
	localparam logic [13:0] FRAME_CODING_ADDR = {FRAME_CODING_IDX, 2'b00};
	localparam logic [13:0] SHAPING_ADDR      = {SHAPING_IDX,      2'b00};
	localparam int          REG_ADDR_BITS     = 14;

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0] RATE_INDEX_RESET   = 8'h00;
	localparam logic [7:0] FRAME_CODING_RESET = 8'h8C;
	localparam logic [7:0] SHAPING_RESET      = 8'h00;

	// ==========================================================
	// writable masks (reserved bits read zero)
	// ==========================================================
	localparam logic [7:0] RATE_INDEX_MASK   = 8'h1F;
	localparam logic [7:0] FRAME_CODING_MASK = 8'hFF;
	localparam logic [7:0] SHAPING_MASK      = 8'h03;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int MOD_INDEX_BIT    = 0;
	localparam int RATE_CODE_LSB    = 1;
	localparam int RATE_CODE_MSB    = 4;
	localparam int RX_FEC_EN_BIT    = 0;
	localparam int ENCODER_TYPE_BIT = 1;
	localparam int CRC_LEN_BIT      = 2;
	localparam int WHITENING_BIT    = 3;
	localparam int HDR_BIT1_BIT     = 4;
	localparam int HDR_BIT2_BIT     = 5;
	localparam int INTERLEAVE_BIT   = 6;
	localparam int RX_MS_CLEAR_BIT  = 7;
	localparam int TX_SHAPING_BIT   = 0;
	localparam int RX_SHAPING_BIT   = 1;

	// ==========================================================
	// data rates in units of 100 bps, indexed by rate code
	// ==========================================================
	localparam int RATE_W = 12;
	localparam logic [RATE_W-1:0] RATE_100BPS [16] = '{
		12'h1F4, 12'h3E8, 12'h5DC, 12'h7D0, 12'h064, 12'h0C8, 12'h000, 12'h000,
		12'h060, 12'h0C0, 12'h180, 12'h480, 12'h000, 12'h000, 12'h000, 12'h000
	};
	localparam logic [15:0] RATE_ALLOWED = 16'h0F3F;

	// ==========================================================
	// axi responses
	// ==========================================================
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		FSKCFG_SEL_RATE    = 2'b00,
		FSKCFG_SEL_CODING  = 2'b01,
		FSKCFG_SEL_SHAPING = 2'b10,
		FSKCFG_SEL_NONE    = 2'b11
	} fskcfg_sel_t;

endpackage

// file: dv/fskcfg_monitor.sv
// fskcfg_monitor: concurrent checks on the fsk config register bank ports.
// assumes binding onto fskcfg_regs, one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fskcfg_monitor #(
	parameter int ADDR_W = 16
) (
	input wire logic              i_clk,
	input wire logic              i_reset,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic              i_s_axi_arvalid,
	input wire logic              o_s_axi_arready,
	input wire logic [31:0]       o_s_axi_rdata,
	input wire logic              i_cca_rate_override,
	input wire logic [3:0]        i_cca_rate_code,
	input wire logic              i_cca_mod_index_sel,
	input wire logic              i_ack_reply_active,
	input wire logic              i_ack_rx_crc_len_sel,
	input wire logic              i_rx_ms_bit,
	input wire logic [3:0]        o_rate_code,
	input wire logic              o_mod_index_sel,
	input wire logic [11:0]       o_rate_100bps,
	input wire logic              o_rate_prohibited,
	input wire logic [3:0]        o_cca_rate_code,
	input wire logic              o_cca_mod_index_sel,
	input wire logic              o_crc_len_sel,
	input wire logic              o_rx_ms_clear,
	input wire logic              o_rx_ms_bit,
	input wire logic              o_interleave_en,
	input wire logic              o_rx_fec_en,
	input wire logic              o_tx_shaping_sel,
	input wire logic              o_rx_shaping_sel
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// ==========================================================
	// read address phase accepted
	// ==========================================================
	sequence s_ar(logic [13:0] a);
		i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == ADDR_W'(a);
	endsequence

	// ==========================================================
	// properties
	// ==========================================================
	property p_rate_lut;
		o_rate_code == 4'hB |-> o_rate_100bps == 12'h480 && !o_rate_prohibited;
	endproperty
	property p_rate_bad;
		o_rate_code[2:1] == 2'h3 || o_rate_code[3:2] == 2'h3 |->
			o_rate_prohibited && o_rate_100bps == 12'h000;
	endproperty
	property p_reset_vals;
		$fell(i_reset) |-> o_rate_code == 4'h0 && !o_mod_index_sel && o_rx_ms_clear &&
			!o_interleave_en && !o_rx_fec_en && !o_tx_shaping_sel && !o_rx_shaping_sel;
	endproperty
	property p_crc_ack;
		i_ack_reply_active |=> o_crc_len_sel == $past(i_ack_rx_crc_len_sel);
	endproperty
	property p_ms_clear;
		o_rx_ms_bit == ($past(i_rx_ms_bit) && !o_rx_ms_clear);
	endproperty
	property p_cca_ovr;
		i_cca_rate_override |=> o_cca_rate_code == $past(i_cca_rate_code) &&
			o_cca_mod_index_sel == $past(i_cca_mod_index_sel);
	endproperty
	property p_cca_own;
		!i_cca_rate_override |=> o_cca_rate_code == o_rate_code &&
			o_cca_mod_index_sel == o_mod_index_sel;
	endproperty
	property p_rsv_rate;
		s_ar(fskcfg_pkg::RATE_INDEX_ADDR) |=> o_s_axi_rdata[31:5] == 27'h0;
	endproperty
	property p_rsv_shape;
		s_ar(fskcfg_pkg::SHAPING_ADDR) |=> o_s_axi_rdata[31:2] == 30'h0;
	endproperty

	a_rate_lut: assert property (p_rate_lut)
		else $error("rate code B not decoded to 115.2 kbps");
	a_rate_bad: assert property (p_rate_bad)
		else $error("prohibited rate code not flagged");
	a_reset_vals: assert property (p_reset_vals)
		else $error("config outputs wrong after reset");
	a_crc_ack: assert property (p_crc_ack)
		else $error("ack reply crc length not taken from frame");
	a_ms_clear: assert property (p_ms_clear)
		else $error("received mode-switch bit handled wrongly");
	a_cca_ovr: assert property (p_cca_ovr)
		else $error("cca override settings not used");
	a_cca_own: assert property (p_cca_own)
		else $error("cca settings differ from own rate settings");
	a_rsv_rate: assert property (p_rsv_rate)
		else $error("rate register reserved bits not zero");
	a_rsv_shape: assert property (p_rsv_shape)
		else $error("shaping register reserved bits not zero");
endmodule

bind fskcfg_regs fskcfg_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

// file: dv/fskcfg_regs_tb.sv
// fskcfg_regs_tb: self-checking bench for the fsk config register bank.
// assumes fskcfg_pkg compiled first; acts as axi4-lite master itself.
`timescale 1ns/1ps
`default_nettype none
module fskcfg_regs_tb;
	logic        i_clk = '0, i_reset = '1;
	logic [15:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
	logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata;
	logic [3:0]  i_s_axi_wstrb = '0, i_cca_rate_code = '0, o_rate_code, o_cca_rate_code;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
	logic [11:0] o_rate_100bps, o_cca_rate_100bps;
	logic        i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0;
	logic        i_s_axi_arvalid = '0, i_s_axi_rready = '0, i_cca_rate_override = '0;
	logic        i_cca_mod_index_sel = '0, i_ack_reply_active = '0, i_ack_rx_crc_len_sel = '0;
	logic        i_rx_ms_bit = '0, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic        o_s_axi_arready, o_s_axi_rvalid, o_mod_index_sel, o_rate_prohibited;
	logic        o_cca_mod_index_sel, o_cca_rate_prohibited, o_rx_fec_en, o_encoder_type_sel;
	logic        o_crc_len_sel, o_whitening_en, o_hdr_bit1_tx, o_hdr_bit2_tx, o_interleave_en;
	logic        o_interleave_conflict, o_rx_ms_clear, o_rx_ms_bit, o_rx_shaping_sel;
	logic        o_tx_shaping_sel;
	int          err_total = 0, n_compared = 0, cyc = 0;
	localparam logic [15:0] A_R = 16'(fskcfg_pkg::RATE_INDEX_ADDR);
	localparam logic [15:0] A_C = 16'(fskcfg_pkg::FRAME_CODING_ADDR);
	localparam logic [15:0] A_S = 16'(fskcfg_pkg::SHAPING_ADDR);
	localparam logic [1:0]  OK = fskcfg_pkg::RESP_OKAY;
	localparam logic [1:0]  ER = fskcfg_pkg::RESP_SLVERR;

	fskcfg_regs #(.ADDR_W(16)) dut (.*);

	initial forever #5 i_clk = ~i_clk;

	// ==========================================================
	// hang guard
	// ==========================================================
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test();
		end
	end

	// ==========================================================
	// compare and bus tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: response %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic ah, wh, bh;
		@(posedge i_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= {24'h000000, d};
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		do begin
			@(negedge i_clk);
			ah = o_s_axi_awready;
			wh = o_s_axi_wready;
			bh = o_s_axi_bvalid;
			@(posedge i_clk);
			if (ah)
				i_s_axi_awvalid <= 1'h0;
			if (wh)
				i_s_axi_wvalid <= 1'h0;
		end while (bh !== 1'h1);
		i_s_axi_bready <= 1'h0;
		chk_resp(o_s_axi_bresp, er);
	endtask

	task automatic rdr(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah, bh;
		@(posedge i_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		do begin
			@(negedge i_clk);
			ah = o_s_axi_arready;
			bh = o_s_axi_rvalid;
			@(posedge i_clk);
			if (ah)
				i_s_axi_arvalid <= 1'h0;
		end while (bh !== 1'h1);
		i_s_axi_rready <= 1'h0;
		chk(o_s_axi_rdata, ed);
		chk_resp(o_s_axi_rresp, er);
	endtask

	// wait until registered config outputs have followed
	task automatic settle;
		repeat (2) @(posedge i_clk);
		#1;
	endtask

	task automatic fin(input string n);
		$display("test %s finished, mismatches so far %0d", n, err_total);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// tests
	// ==========================================================
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 1'h0;
		settle();
		rdr(A_R, 32'h00, OK);
		rdr(A_C, 32'h8C, OK);
		rdr(A_S, 32'h00, OK);
		chk({o_rx_ms_clear, o_interleave_en, o_hdr_bit2_tx, o_hdr_bit1_tx, o_whitening_en,
			o_crc_len_sel, o_encoder_type_sel, o_rx_fec_en}, 32'h8C);
		chk({o_rx_shaping_sel, o_tx_shaping_sel, o_rate_100bps}, 32'h1F4);
		fin("reset");
		for (int c = 0; c < 16; c++) begin
			wr(A_R, 8'(c * 2 + c % 2), 4'hF, OK);
			settle();
			chk(o_rate_code, 32'(c));
			chk(o_rate_100bps, fskcfg_pkg::RATE_100BPS[c]);
			chk(o_rate_prohibited, 32'(fskcfg_pkg::RATE_100BPS[c] == 12'h000));
			chk(o_mod_index_sel, 32'(c % 2));
			rdr(A_R, 32'(c * 2 + c % 2), OK);
		end
		wr(A_R, 8'hFF, 4'hF, OK);
		rdr(A_R, 32'h1F, OK);
		fin("rate");
		for (int b = 0; b < 8; b++) begin
			wr(A_C, 8'h01 << b, 4'hF, OK);
			settle();
			chk({o_rx_ms_clear, o_interleave_en, o_hdr_bit2_tx, o_hdr_bit1_tx, o_whitening_en,
				o_crc_len_sel, o_encoder_type_sel, o_rx_fec_en}, 32'h1 << b);
			chk(o_interleave_conflict, 32'(b != 1 && b != 6));
			rdr(A_C, 32'h1 << b, OK);
		end
		fin("coding");
		for (int v = 0; v < 8; v++) begin
			wr(A_S, (v < 4) ? 8'(v) : (8'hFC | 8'(v)), 4'hF, OK);
			settle();
			chk({o_rx_shaping_sel, o_tx_shaping_sel}, 32'(v % 4));
			rdr(A_S, 32'(v % 4), OK);
		end
		fin("shaping");
		wr(A_C, 8'h40, 4'hF, OK);
		@(posedge i_clk);
		i_ack_reply_active <= 1'h1;
		i_ack_rx_crc_len_sel <= 1'h1;
		settle();
		chk(o_crc_len_sel, 32'h1);
		@(posedge i_clk);
		i_ack_rx_crc_len_sel <= 1'h0;
		wr(A_C, 8'h44, 4'hF, OK);
		settle();
		chk(o_crc_len_sel, 32'h0);
		@(posedge i_clk);
		i_ack_reply_active <= 1'h0;
		settle();
		chk(o_crc_len_sel, 32'h1);
		fin("ack crc");
		@(posedge i_clk);
		i_rx_ms_bit <= 1'h1;
		settle();
		chk(o_rx_ms_bit, 32'h1);
		wr(A_C, 8'hC4, 4'hF, OK);
		settle();
		chk(o_rx_ms_bit, 32'h0);
		fin("ms clear");
		wr(A_R, 8'h07, 4'hF, OK);
		settle();
		chk({o_cca_mod_index_sel, o_cca_rate_code, o_cca_rate_100bps}, 32'h137D0);
		@(posedge i_clk);
		i_cca_rate_override <= 1'h1;
		i_cca_rate_code <= 4'h9;
		settle();
		chk({o_cca_mod_index_sel, o_cca_rate_code, o_cca_rate_100bps}, 32'h090C0);
		@(posedge i_clk);
		i_cca_rate_code <= 4'hD;
		i_cca_mod_index_sel <= 1'h1;
		settle();
		chk({o_cca_rate_prohibited, o_cca_mod_index_sel, o_cca_rate_code}, 32'h3D);
		fin("cca");
		wr(16'h058C, 8'h55, 4'hF, ER);
		rdr(16'h058C, 32'h0, ER);
		wr(A_R, 8'h02, 4'h0, OK);
		rdr(A_R, 32'h07, OK);
		fin("bus");
		end_of_test();
	end
endmodule
`default_nettype wire
